// ==== hw/change_detect.sv ====
/*
 * Change detector: optionally passes a bus through a two-stage
 * synchroniser, then raises a one-cycle pulse per bit that changed.
 * Assumes one clock, a synchronous active-high reset and a clock enable.
 */
`timescale 1ns/1ps

module change_detect
  import event_latch_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter bit SYNC  = 1'b1
) (
  // Clock, reset and enable.
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             clk_en,
  // Watched level and its change pulses.
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] changed
);

  // Samples that must pass after reset before the compare is trusted:
  // the synchroniser chain plus the previous-value flop must all hold pin
  // data, or a pin that sits high through reset would show a false change.
  localparam logic [1:0] PRIME_LEN = SYNC ? 2'(SYNC_STAGES + 1) : 2'h1;

  logic [WIDTH-1:0] prev_reg;
  logic [1:0]       prime_cnt_reg;
  logic             primed;
  logic [WIDTH-1:0] level_now;

  //////////////////////////////////////////////////////////////////////////
  // Input stage: two flip-flops for pins, a plain wire for local logic.
  generate
    if (SYNC) begin : g_sync
      logic [WIDTH-1:0] stage1_reg;
      logic [WIDTH-1:0] stage2_reg;

      // The first stage feeds only the second stage.
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          stage1_reg <= '0;
          stage2_reg <= '0;
        end else if (clk_en) begin
          stage1_reg <= level_in;
          stage2_reg <= stage1_reg;
        end
      end
      assign level_now = stage2_reg;
    end else begin : g_direct
      assign level_now = level_in;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Previous value and priming count; the first samples after reset only
  // fill the chain so that the level the pins sit at is not a change.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev_reg      <= '0;
      prime_cnt_reg <= 2'h0;
    end else if (clk_en) begin
      prev_reg <= level_now;
      if (!primed) begin
        prime_cnt_reg <= prime_cnt_reg + 2'h1;
      end
    end
  end

  // Compare is trusted once the whole chain holds sampled pin data.
  assign primed = (prime_cnt_reg == PRIME_LEN);

  // Change pulse, one bit per watched line.
  assign changed = (primed && clk_en) ? (level_now ^ prev_reg) : '0;

endmodule

// ==== hw/event_change_latch.sv ====
/*
 * Event change latch of a four-port video switch: tracks which
 * system-level events raised the interrupt request and shows them in the
 * read-only event_change_flags register at offset 0x07.
 * Assumes a register port driven by the local serial slave on clk_sys;
 * the active port code comes from logic on the same clock, while the
 * clock-detect and source power sense levels arrive from pins.
 */
// What this block does
// - Bit 5 flags selected port change since read
// - Bit 4 flags selected port clock-detect change
// - Bits 0-3 flag power sense change, ports 1-4
// - All flags read zero after reset
// - Register is read-only; writes change nothing
// - Flags captured whenever an event raises interrupt
// - Reading 0x01 clears interrupt and flags; a same-cycle event still sets both
// - Unread, capture keeps updating on each event
`timescale 1ns/1ps

module event_change_latch
  import event_latch_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
) (
  // Clock, reset and enable.
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic                  clk_en,
  // Switch state.
  input  wire logic [SEL_WIDTH-1:0]  active_port,
  input  wire logic                  sel_clock_detect,
  input  wire logic [PORTS-1:0]      source_power_sense,
  // Register port.
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_rd,
  input  wire logic                  reg_wr,
  input  wire logic [DATA_WIDTH-1:0] reg_wdata,
  output logic      [DATA_WIDTH-1:0] reg_rdata,
  output logic                       reg_rvalid,
  // Interrupt request.
  output logic                       irq
);

  logic                  sel_changed;
  logic                  clk_det_changed;
  logic [PORTS-1:0]      power_changed;
  logic [SEL_WIDTH-1:0]  sel_diff;
  logic [FLAG_WIDTH-1:0] new_events;
  logic                  any_event;
  logic                  status_read;
  logic [FLAG_WIDTH-1:0] flags_reg;
  logic [FLAG_WIDTH-1:0] flags_next;
  logic                  irq_reg;
  logic                  irq_next;
  logic [DATA_WIDTH-1:0] rdata_reg;
  logic [DATA_WIDTH-1:0] rdata_next;
  logic                  rvalid_reg;

  //////////////////////////////////////////////////////////////////////////
  // Event sources.

  // Active port code comes from local logic, so no synchroniser.
  change_detect #(
    .WIDTH (SEL_WIDTH),
    .SYNC  (1'b0)
  ) u_sel_change (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .clk_en   (clk_en),
    .level_in (active_port),
    .changed  (sel_diff)
  );

  // Clock-detect status of the selected port arrives from a pin.
  change_detect #(
    .WIDTH (1),
    .SYNC  (1'b1)
  ) u_clk_det_change (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .clk_en   (clk_en),
    .level_in (sel_clock_detect),
    .changed  (clk_det_changed)
  );

  // Source power sense lines, one per port, arrive from pins.
  change_detect #(
    .WIDTH (PORTS),
    .SYNC  (1'b1)
  ) u_power_change (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .clk_en   (clk_en),
    .level_in (source_power_sense),
    .changed  (power_changed)
  );

  // Gather the events of this cycle into the register layout.
  always_comb begin
    sel_changed = |sel_diff;
    new_events  = FLAGS_RESET;
    new_events[PORT_SEL_BIT]   = sel_changed;
    new_events[CLK_DETECT_BIT] = clk_det_changed;
    new_events[POWER_LSB_BIT +: PORTS] = power_changed;
    any_event = |new_events;
  end

  //////////////////////////////////////////////////////////////////////////
  // Register access decode.

  // A read of the interrupt status register clears the interrupt.
  assign status_read = clk_en && reg_rd && (reg_addr == IRQ_STATUS_OFFSET);

  // Writes reach no storage here; the flags are read-only, so the write
  // strobe and write data are left unread on purpose and no write path
  // exists into the captured flags.

  //////////////////////////////////////////////////////////////////////////
  // Interrupt request and captured flags.
  //
  // Each event raises the request and folds into the captured flags, so
  // an unread register keeps gathering events. A status read clears
  // both, but an event in the same cycle survives the clear.
  always_comb begin
    irq_next   = irq_reg;
    flags_next = flags_reg;
    if (status_read) begin
      irq_next   = 1'b0;
      flags_next = FLAGS_RESET;
    end
    if (any_event) begin
      irq_next   = 1'b1;
      flags_next = flags_next | new_events;
    end
  end

  // Interrupt request state.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg <= irq_next;
    end
  end

  // Captured change flags; zero after reset.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags_reg <= FLAGS_RESET;
    end else if (clk_en) begin
      flags_reg <= flags_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data mux; unmapped offsets and reserved bits read zero.
  always_comb begin
    rdata_next = READ_ZERO;
    case (reg_addr)
      EVENT_CHANGE_OFFSET: begin
        rdata_next[FLAG_WIDTH-1:0] = flags_reg;
      end
      IRQ_STATUS_OFFSET: begin
        rdata_next[IRQ_PENDING_BIT] = irq_reg;
      end
      default: begin
        rdata_next = READ_ZERO;
      end
    endcase
  end

  // Registered read answer, one cycle after the read strobe.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg  <= READ_ZERO;
      rvalid_reg <= 1'b0;
    end else if (clk_en) begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Outputs come straight from flip-flops.
  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign irq        = irq_reg;

endmodule

// ==== pkg/event_latch_pkg.sv ====
/*
 * Constants for the switch event change latch: register offsets, field
 * positions, widths and reset values.
 * Assumes it is compiled before every design file that imports it.
 */
package event_latch_pkg;

  // Register offsets on the local register port.
  localparam logic [7:0] IRQ_STATUS_OFFSET   = 8'h01;
  localparam logic [7:0] EVENT_CHANGE_OFFSET = 8'h07;

  // Widths of the flag fields and of the port select.
  localparam int NUM_PORTS    = 4;
  localparam int SEL_WIDTH    = 2;
  localparam int DATA_WIDTH   = 8;
  localparam int SYNC_STAGES  = 2;

  // Field positions inside the event change flags register.
  localparam int POWER_LSB_BIT   = 0;
  localparam int CLK_DETECT_BIT  = 4;
  localparam int PORT_SEL_BIT    = 5;
  localparam int FLAG_WIDTH      = 6;

  // Field position of the pending bit in the interrupt status register.
  localparam int IRQ_PENDING_BIT = 0;

  // Reset and idle values.
  localparam logic [FLAG_WIDTH-1:0] FLAGS_RESET = 6'h00;
  localparam logic [DATA_WIDTH-1:0] READ_ZERO   = 8'h00;

endpackage

// ==== verif/event_latch_monitor.sv ====
/* Checker for the event change latch ports.
   Assumes a bind onto event_change_latch from the bench top file. */
`timescale 1ns/1ps
module event_latch_monitor
  import event_latch_pkg::*;
(
  // Clock and reset.
  input wire logic                  clk_sys,
  input wire logic                  srst,
  input wire logic                  clk_en,
  // Watched ports.
  input wire logic [SEL_WIDTH-1:0]  active_port,
  input wire logic [7:0]            reg_addr,
  input wire logic                  reg_rd,
  input wire logic                  reg_wr,
  input wire logic [DATA_WIDTH-1:0] reg_rdata,
  input wire logic                  reg_rvalid,
  input wire logic                  irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Reads taken at this edge, by offset.
  wire logic clr_rd = reg_rd && clk_en && reg_addr == IRQ_STATUS_OFFSET;
  wire logic flg_rd = reg_rd && clk_en && reg_addr == EVENT_CHANGE_OFFSET;
  AST_RESET_IDLE: assert property ($past(srst) |-> !irq && !reg_rvalid)
    else $error("Outputs not idle after reset.");
  AST_IDLE_FLAGS: assert property (flg_rd && !irq |=> reg_rdata == READ_ZERO)
    else $error("Flags set with no pending event.");
  AST_PORT_EVENT: assert property (clk_en && $past(clk_en) && !$past(srst)
    && $changed(active_port) |=> irq)
    else $error("Port change raised no interrupt.");
  AST_CAPTURE: assert property (flg_rd && irq |=> reg_rdata[5:0] != 6'h00)
    else $error("Interrupt pending but no flag captured.");
  AST_IRQ_HOLD: assert property (irq && !clr_rd |=> irq)
    else $error("Interrupt dropped without a status read.");
  AST_IRQ_CLEAR: assert property (!$past(srst) && $fell(irq) |-> $past(clr_rd))
    else $error("Interrupt cleared without a status read.");
  AST_STATUS_DATA: assert property (clr_rd |=> reg_rvalid
    && reg_rdata == {7'h00, $past(irq)})
    else $error("Status read returned wrong data.");
  AST_WRITE_SILENT: assert property (reg_wr && !reg_rd |=> !reg_rvalid)
    else $error("Write produced an answer.");
  AST_RESERVED: assert property (reg_rvalid |-> reg_rdata[7:6] == 2'h0)
    else $error("Reserved bits read nonzero.");
endmodule

// ==== verif/host_model.sv ====
/* Host side model: turns bench requests into register port strobes.
   Assumes requests are one cycle long and come after a clock edge. */
`timescale 1ns/1ps
module host_model (
  // Clock.
  input wire logic       clk_sys,
  // Requests from the bench.
  input wire logic       req_rd,
  input wire logic       req_wr,
  input wire logic [7:0] req_addr,
  // Register port strobes.
  output logic           reg_rd    = 1'b0,
  output logic           reg_wr    = 1'b0,
  output logic     [7:0] reg_addr  = 8'h00,
  output logic     [7:0] reg_wdata = 8'hA5
);
  // Idle address and data lines flip so stale values are never trusted.
  always @(posedge clk_sys) begin
    reg_rd    <= req_rd;
    reg_wr    <= req_wr;
    reg_addr  <= (req_rd || req_wr) ? req_addr : ~reg_addr;
    reg_wdata <= ~reg_wdata;
  end
endmodule

// ==== verif/tb_top.sv ====
/* Top bench for the event change latch with random event traffic.
   Assumes the package, design, checker and host model compile first. */
`timescale 1ns/1ps
module tb_top import event_latch_pkg::*;;
  logic             clk_sys = 1'b0;
  logic             srst    = 1'b1;
  logic             clk_en  = 1'b1;
  logic [1:0]       active_port = 2'h0;
  logic             clk_det = 1'b0;
  logic [3:0]       pwr     = 4'h0;
  logic             req_rd  = 1'b0;
  logic             req_wr  = 1'b0;
  logic [7:0]       req_addr = 8'h00;
  wire logic        reg_rd, reg_wr, reg_rvalid, irq;
  wire logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  int               fails = 0, checks_done = 0, cyc = 0, seed = 32'h71850410;

  always #50 clk_sys = ~clk_sys;

  event_change_latch u_event_change_latch (.clk_sys(clk_sys), .srst(srst),
    .clk_en(clk_en), .active_port(active_port), .sel_clock_detect(clk_det),
    .source_power_sense(pwr), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .irq(irq));
  host_model u_host_model (.clk_sys(clk_sys), .req_rd(req_rd),
    .req_wr(req_wr), .req_addr(req_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Issues one read and waits a bounded time for its answer.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    req_rd <= 1'b1;
    req_addr <= a;
    @(posedge clk_sys);
    req_rd <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (reg_rvalid !== 1'b1 && n < 5);
    check("read answer", {7'h00, reg_rvalid}, 8'h01);
    d = reg_rdata;
  endtask

  // Flag bit expected for event kind k: 0-3 power, 4 clock-detect, 5 port.
  function automatic logic [7:0] flag_of(input int k);
    return 8'h01 << (k < 4 ? POWER_LSB_BIT + k :
                     k == 4 ? CLK_DETECT_BIT : PORT_SEL_BIT);
  endfunction

  // Applies one event and lets it pass the pin synchronisers.
  task automatic fire(input int k);
    if (k < 4) pwr[k] <= ~pwr[k];
    else if (k == 4) clk_det <= ~clk_det;
    else active_port <= active_port + 2'h1;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      stop_test();
    end
  end

  // Main sequence: reset, a write attempt, random event pairs, a frozen
  // enable, an unmapped read and a mid-run reset with pins held high.
  initial begin
    logic [7:0] d, exp;
    int k;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(EVENT_CHANGE_OFFSET, d);
    check("flags after reset", d, READ_ZERO);
    req_wr <= 1'b1;
    req_addr <= EVENT_CHANGE_OFFSET;
    @(posedge clk_sys);
    req_wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(EVENT_CHANGE_OFFSET, d);
    check("flags after write", d, READ_ZERO);
    for (int i = 0; i < 20; i++) begin
      k = {$random(seed)} % 6;
      exp = flag_of(k);
      fire(k);
      k = {$random(seed)} % 6;
      exp |= flag_of(k);
      fire(k);
      check("irq", {7'h00, irq}, 8'h01);
      rd(EVENT_CHANGE_OFFSET, d);
      check("flags", d, exp);
      rd(IRQ_STATUS_OFFSET, d);
      check("status", d, 8'h01);
      rd(EVENT_CHANGE_OFFSET, d);
      check("flags cleared", d, READ_ZERO);
    end
    // A status read while the enable is low is not taken.
    fire(5);
    clk_en <= 1'b0;
    req_rd <= 1'b1;
    req_addr <= IRQ_STATUS_OFFSET;
    @(posedge clk_sys);
    req_rd <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("frozen rvalid", {7'h00, reg_rvalid}, 8'h00);
    check("frozen irq", {7'h00, irq}, 8'h01);
    clk_en <= 1'b1;
    rd(8'h00, d);
    check("unmapped", d, READ_ZERO);
    rd(EVENT_CHANGE_OFFSET, d);
    check("flags kept", d, flag_of(5));
    rd(IRQ_STATUS_OFFSET, d);
    check("status late", d, 8'h01);
    // Pin levels held high through a reset are not events.
    srst <= 1'b1;
    pwr <= 4'hF;
    clk_det <= 1'b1;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check("irq after mid reset", {7'h00, irq}, 8'h00);
    rd(EVENT_CHANGE_OFFSET, d);
    check("flags after mid reset", d, READ_ZERO);
    fire(0);
    rd(EVENT_CHANGE_OFFSET, d);
    check("flags event after reset", d, flag_of(0));
    stop_test();
  end
endmodule

bind event_change_latch event_latch_monitor u_event_latch_monitor (
  .clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
  .active_port(active_port), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .irq(irq));
